/* File: logic/ars_pkg.sv */
/*
 shared constants for the shift datapath: opcodes, instruction field positions,
 widths and reset values.
 assumes 16-bit words with bit 0 as the most significant bit of each word.
*/
package ars_pkg;
   localparam int WORD_W = 16;
   localparam int CNT_W = 4;
   localparam int REG_N = 8;
   localparam int RIDX_W = 3;
   // opcodes
   localparam logic [7:0] OP_ARITH_RIGHT_PAIR_BY_LITERAL = 8'h5F;
   localparam logic [7:0] OP_ARITH_RIGHT_PAIR_BY_REG = 8'h3F;
   localparam logic [7:0] OP_ARITH_RIGHT_WORD_BY_LITERAL = 8'h4F;
   localparam logic [7:0] OP_ARITH_RIGHT_WORD_BY_REG = 8'h2F;
   localparam logic [7:0] OP_ZERO_LEFT_PAIR_BY_LITERAL = 8'h5C;
   localparam logic [7:0] OP_ZERO_LEFT_PAIR_BY_REG = 8'h3C;
   // field positions, counted in the vector's own numbering (vector bit 15 = word bit 0)
   localparam int OPC_LSB = 8;
   localparam int LIT_LSB = 4;
   localparam int IND_BIT = 7;
   localparam int SRC_LSB = 4;
   localparam int TGT_LSB = 0;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [2:0] LAST_REG = 3'h7;
   typedef enum logic [2:0] {
      ARS_NONE,
      ARS_AR_PAIR,
      ARS_AR_WORD,
      ARS_ZL_PAIR
   } ars_kind_t;
   typedef enum {
      ARS_IDLE,
      ARS_FETCH,
      ARS_WRITE
   } ars_state_t;
endpackage

/* File: logic/ars_shift_core.sv */
/*
 combinational shifter for one 32-bit pair or one 16-bit word.
 assumes the caller presents operands already aligned high word first.
*/
`timescale 1ns/100ps
module ars_shift_core
   import ars_pkg::*;
(
   input wire ars_pkg::ars_kind_t kind,
   input wire logic [3:0] count,
   input wire logic [15:0] hi_word,
   input wire logic [15:0] lo_word,
   output logic [15:0] hi_out,
   output logic [15:0] lo_out
);
   logic [31:0] pair;
   logic [31:0] shifted;
   always_comb begin
      pair = {hi_word, lo_word};
      shifted = pair;
      hi_out = hi_word;
      lo_out = lo_word;
      unique case (kind)
         ARS_AR_PAIR: begin
            shifted = $signed(pair) >>> count;
            hi_out = shifted[31:16];
            lo_out = shifted[15:0];
         end
         ARS_AR_WORD: begin
            hi_out = 16'($signed(hi_word) >>> count);
         end
         ARS_ZL_PAIR: begin
            shifted = pair << count;
            hi_out = shifted[31:16];
            lo_out = shifted[15:0];
         end
         default: begin
            shifted = pair;
         end
      endcase
   end
endmodule

/* File: logic/ars_shifter.sv */
/*
 shift execution unit holding the eight general registers.
 assumes the decoder presents one instruction with instr_valid for one cycle
 and that operand memory answers a read with mem_rd_valid some cycles later.
*/
// Operation
// - literal count is unsigned four bits at instruction bits 8-11, range 0-15.
// - register form takes count from named register, or memory when indirect.
// - double shift pairs target register high word with next register low.
// - target register 7 pairs with register 0 as low word.
// - arithmetic right shifts copy sign bit 0 into vacated positions.
// - arithmetic double right shifts pair, sign-extends, drops low-end bits.
// - arithmetic single right shifts one word, sign-extends, drops low bits.
// - logical left double shifts pair, zero fills, drops high-word overflow.
// - opcodes 5F, 3F, 4F and 2F select arithmetic right forms.
// - opcodes 5C and 3C select logical left double forms.
`timescale 1ns/100ps
module ars_shifter
   import ars_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   output logic instr_ready,
   output logic mem_rd_req,
   output logic [15:0] mem_rd_addr,
   input wire logic mem_rd_valid,
   input wire logic [15:0] mem_rd_data,
   input wire logic wr_en,
   input wire logic [2:0] wr_sel,
   input wire logic [15:0] wr_data,
   input wire logic [2:0] rd_sel,
   output logic [15:0] rd_data,
   output logic done,
   output logic illegal
);
   import ars_pkg::*;

   logic [15:0] gpr [REG_N];
   ars_state_t state;
   ars_kind_t kind;
   logic [3:0] count;
   logic [2:0] target;
   logic [15:0] hi_new;
   logic [15:0] lo_new;
   ars_kind_t next_kind;
   logic next_reg_form;

   function automatic logic [2:0] pair_low(input logic [2:0] r);
      pair_low = (r == LAST_REG) ? 3'h0 : 3'(r + 3'h1);
   endfunction

   // a count word carries its shift amount in the low four bits of the vector
   function automatic logic [3:0] word_count(input logic [15:0] w);
      word_count = w[CNT_W-1:0];
   endfunction

   wire [7:0] opc = instr_word[OPC_LSB +: 8];
   wire ind = instr_word[IND_BIT];
   wire [2:0] src = instr_word[SRC_LSB +: RIDX_W];
   wire [2:0] tgt = instr_word[TGT_LSB +: RIDX_W];
   wire [3:0] lit = instr_word[LIT_LSB +: CNT_W];

   always_comb begin
      next_kind = ARS_NONE;
      next_reg_form = 1'b0;
      unique case (opc)
         OP_ARITH_RIGHT_PAIR_BY_LITERAL: next_kind = ARS_AR_PAIR;
         OP_ARITH_RIGHT_PAIR_BY_REG: begin
            next_kind = ARS_AR_PAIR;
            next_reg_form = 1'b1;
         end
         OP_ARITH_RIGHT_WORD_BY_LITERAL: next_kind = ARS_AR_WORD;
         OP_ARITH_RIGHT_WORD_BY_REG: begin
            next_kind = ARS_AR_WORD;
            next_reg_form = 1'b1;
         end
         OP_ZERO_LEFT_PAIR_BY_LITERAL: next_kind = ARS_ZL_PAIR;
         OP_ZERO_LEFT_PAIR_BY_REG: begin
            next_kind = ARS_ZL_PAIR;
            next_reg_form = 1'b1;
         end
         default: next_kind = ARS_NONE;
      endcase
   end

   ars_shift_core u_core (
      .kind(kind),
      .count(count),
      .hi_word(gpr[target]),
      .lo_word(gpr[pair_low(target)]),
      .hi_out(hi_new),
      .lo_out(lo_new)
   );

   // instructions are taken in idle only; anything offered mid-shift is ignored
   wire take = (state == ARS_IDLE) && instr_valid;
   wire fetch_ind = next_reg_form && ind;

   // sequencing: idle, optional memory count fetch, one write-back cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ARS_IDLE;
      end else begin
         unique case (state)
            ARS_IDLE: begin
               if (take && (next_kind != ARS_NONE)) begin
                  if (fetch_ind) begin
                     state <= ARS_FETCH;
                  end else begin
                     state <= ARS_WRITE;
                  end
               end
            end
            ARS_FETCH: begin
               if (mem_rd_valid) begin
                  state <= ARS_WRITE;
               end
            end
            ARS_WRITE: begin
               state <= ARS_IDLE;
            end
         endcase
      end
   end

   // operand latch: kind and target stay put until the next take
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         kind <= ARS_NONE;
         target <= 3'h0;
      end else if (take) begin
         kind <= next_kind;
         target <= tgt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count <= 4'h0;
      end else if (take) begin
         if (next_reg_form) begin
            count <= word_count(gpr[src]);
         end else begin
            count <= lit;
         end
      end else if ((state == ARS_FETCH) && mem_rd_valid) begin
         count <= word_count(mem_rd_data);
      end
   end

   // memory count fetch: one-cycle request, address held until the next fetch
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mem_rd_req <= 1'b0;
         mem_rd_addr <= WORD_RESET;
      end else begin
         mem_rd_req <= take && fetch_ind;
         if (take && fetch_ind) begin
            mem_rd_addr <= gpr[src];
         end
      end
   end

   // unknown opcodes are flagged for one cycle and otherwise dropped
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         illegal <= 1'b0;
      end else begin
         illegal <= take && (next_kind == ARS_NONE);
      end
   end

   // the shift writes back in ARS_WRITE; an external write on the same cycle loses
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < REG_N; i++) begin
            gpr[i] <= WORD_RESET;
         end
      end else if (state == ARS_WRITE) begin
         // zero count writes back same values
         gpr[target] <= hi_new;
         if (kind != ARS_AR_WORD) begin
            gpr[pair_low(target)] <= lo_new;
         end
      end else if (wr_en) begin
         gpr[wr_sel] <= wr_data;
      end
   end

   // completion pulse follows the write-back cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else begin
         done <= (state == ARS_WRITE);
      end
   end

   // ready drops after any offer, but take ignores ready, so a request left standing is taken again once idle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         instr_ready <= 1'b0;
      end else begin
         instr_ready <= (state == ARS_IDLE) && !instr_valid;
      end
   end

   // registered read port, one cycle behind rd_sel
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= WORD_RESET;
      end else begin
         rd_data <= gpr[rd_sel];
      end
   end
endmodule

/* File: verification/ars_shifter_sva.sv */
/*
 port checker for the shift unit: decode, fetch and completion timing.
 assumes it is bound to ars_shifter and sees only its ports.
*/
`timescale 1ns/100ps
module ars_shifter_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic instr_ready,
   input wire logic mem_rd_req,
   input wire logic done,
   input wire logic illegal
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic take = instr_valid && instr_ready;
   wire logic [7:0] opc = instr_word[15:8];
   wire logic lit = opc == 8'h5F || opc == 8'h4F || opc == 8'h5C;
   wire logic bad = !(lit || opc == 8'h3F || opc == 8'h2F || opc == 8'h3C);
   bad_op_flag_a: assert property (take && bad |-> ##1 illegal) else $error("unknown opcode not flagged");
   good_op_quiet_a: assert property (take && !bad |-> ##1 !illegal)
      else $error("known opcode flagged");
   bad_no_done_a: assert property (take && bad |-> ##1 !done [*3]) else $error("unknown opcode completed");
   lit_done_a: assert property (take && lit |-> ##2 done) else $error("literal shift late");
   lit_no_fetch_a: assert property (take && lit |-> ##1 !mem_rd_req [*2])
      else $error("literal shift fetched a count");
   ind_fetch_a: assert property (take && !lit && !bad && instr_word[7] |-> ##1 mem_rd_req)
      else $error("indirect count not fetched");
   dir_count_a: assert property (take && !lit && !bad && !instr_word[7] |-> ##1 !mem_rd_req ##1 done)
      else $error("register count shift mistimed");
   fetch_wait_a: assert property (mem_rd_req |-> !done [*2]) else $error("done before memory count");
endmodule
bind ars_shifter ars_shifter_chk i_chk (.clk_sys, .rst_n, .instr_valid, .instr_word, .instr_ready, .mem_rd_req,
   .done, .illegal);

/* File: verification/arith_right_logic_left_shifter_tb_top.sv */
/*
 self-checking bench for the shift unit.
 assumes the bench plays decoder, count memory and register port itself.
*/
`timescale 1ns/100ps
module arith_right_logic_left_shifter_tb_top;
   import ars_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic instr_valid = 1'b0;
   logic mem_rd_valid = 1'b0;
   logic wr_en = 1'b0;
   logic [15:0] instr_word = 16'h0000, mem_rd_data = 16'h0000, wr_data = 16'h0000, v, w;
   logic [2:0] wr_sel = 3'h0, rd_sel = 3'h0;
   wire logic instr_ready, mem_rd_req, done, illegal;
   wire logic [15:0] mem_rd_addr, rd_data;
   int err_total = 0, checked = 0, n;
   always #50 clk_sys = ~clk_sys;
   ars_shifter i_dut (.clk_sys, .rst_n, .instr_valid, .instr_word, .instr_ready, .mem_rd_req, .mem_rd_addr,
      .mem_rd_valid, .mem_rd_data, .wr_en, .wr_sel, .wr_data, .rd_sel, .rd_data, .done, .illegal);
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      wr_en = 1'b1;
      wr_sel = s;
      wr_data = d;
      step();
      wr_en = 1'b0;
      step();
   endtask
   task automatic rd(input logic [2:0] s, output logic [15:0] d);
      rd_sel = s;
      step();
      d = rd_data;
   endtask
   task automatic pair(input logic [2:0] t, input logic [31:0] e);
      rd(t, v);
      rd(t + 3'h1, w);
      chk("pair", e, {v, w});
   endtask
   task automatic offer(input logic [15:0] i);
      for (n = 0; n < 20 && instr_ready !== 1'b1; n++) step();
      chk("ready", 32'h1, instr_ready);
      if (instr_ready !== 1'b1) finish_test();
      instr_valid = 1'b1;
      instr_word = i;
      step();
      instr_valid = 1'b0;
   endtask
   // memory answers promptly; outside the answer it shows the inverse pattern
   task automatic run(input logic [15:0] i, input logic [15:0] m);
      offer(i);
      for (n = 0; n < 20 && done !== 1'b1; n++) begin
         mem_rd_valid = mem_rd_req;
         mem_rd_data = mem_rd_req ? m : ~m;
         step();
      end
      chk("done", 32'h1, done);
      if (done !== 1'b1) finish_test();
   endtask
   task automatic s_ar_pair();
      wr(3'h5, 16'h8123);
      wr(3'h6, 16'h4567);
      run({8'h5F, 4'hD, 4'h5}, 16'h0000);
      pair(3'h5, 32'($signed(32'h81234567) >>> 13));
   endtask
   task automatic s_ar_word();
      wr(3'h2, 16'hA5C3);
      wr(3'h3, 16'h1234);
      run({8'h4F, 4'hF, 4'h2}, 16'h0000);
      pair(3'h2, {16'($signed(16'hA5C3) >>> 15), 16'h1234});
      wr(3'h2, 16'h5A3C);
      run({8'h4F, 4'h0, 4'h2}, 16'h0000);
      pair(3'h2, 32'h5A3C1234);
      wr(3'h4, 16'h0003);
      run({8'h2F, 1'b0, 3'h4, 1'b0, 3'h3}, 16'h0000);
      pair(3'h3, 32'h02460003);
   endtask
   task automatic s_zl_wrap();
      wr(3'h7, 16'h8001);
      wr(3'h0, 16'hC003);
      run({8'h5C, 4'hF, 4'h7}, 16'h0000);
      pair(3'h7, 32'h8001C003 << 15);
   endtask
   task automatic s_reg_count();
      wr(3'h3, 16'hFFF7);
      wr(3'h1, 16'h7000);
      wr(3'h2, 16'h0001);
      run({8'h3C, 1'b0, 3'h3, 1'b0, 3'h1}, 16'h0000);
      pair(3'h1, 32'h70000001 << 7);
   endtask
   task automatic s_indirect();
      wr(3'h6, 16'h0ABC);
      wr(3'h4, 16'h9000);
      wr(3'h5, 16'h0F0F);
      run({8'h3F, 1'b1, 3'h6, 1'b0, 3'h4}, 16'h5FF9);
      chk("addr", 32'h0ABC, mem_rd_addr);
      pair(3'h4, 32'($signed(32'h90000F0F) >>> 9));
   endtask
   task automatic s_illegal();
      wr(3'h1, 16'h2468);
      offer({8'h5D, 4'h3, 4'h1});
      chk("illegal", 32'h1, illegal);
      rd(3'h1, v);
      chk("word", 32'h2468, v);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      step();
      s_ar_pair();
      s_ar_word();
      s_zl_wrap();
      s_reg_count();
      s_indirect();
      s_illegal();
      finish_test();
   end
endmodule
